// >>> design/lbcs_pkg.sv
// Purpose: Shared constants and types of the charge sequencer
// Assumes: 50 MHz hclk, timer tick stands in for the capacitor oscillators
// Notes:   Times are kept in their own units; tick counts derive from them
`default_nettype none

package lbcs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and timer base
  localparam int CLK_MHZ        = 50;
  localparam int TICK_PERIOD_US = 1000;
  localparam int TICK_CYCLES    = TICK_PERIOD_US * CLK_MHZ;
  localparam int TICKS_PER_MIN  = 60_000_000 / TICK_PERIOD_US;
  localparam int TIMER_W        = 24;

  ////////////////////////////////////////////////////////////////////////////
  // Safety timeouts, nominal 1 nF timer capacitors
  localparam int PREQ_TIME_DECIMIN = 75;
  localparam int FAST_TIME_MIN     = 90;
  localparam int FULL_TIME_MIN     = 90;
  localparam int TOPOFF_TIME_MIN   = 45;
  localparam int PREQ_TICKS   = PREQ_TIME_DECIMIN * TICKS_PER_MIN / 10;
  localparam int FAST_TICKS   = FAST_TIME_MIN * TICKS_PER_MIN;
  localparam int FULL_TICKS   = FULL_TIME_MIN * TICKS_PER_MIN;
  localparam int TOPOFF_TICKS = TOPOFF_TIME_MIN * TICKS_PER_MIN;

  ////////////////////////////////////////////////////////////////////////////
  // Temperature sampling, rate in centihertz
  localparam int TEMP_RATE_CHZ = 112;
  localparam int TEMP_TICKS    =
    100_000_000 / (TEMP_RATE_CHZ * TICK_PERIOD_US);

  ////////////////////////////////////////////////////////////////////////////
  // Comparator flag positions
  localparam int FLAG_W       = 11;
  localparam int FLG_ABOVE_UV = 0;
  localparam int FLG_AT_REG   = 1;
  localparam int FLG_RECHARGE = 2;
  localparam int FLG_OVERVOLT = 3;
  localparam int FLG_DROPOUT  = 4;
  localparam int FLG_TAPER    = 5;
  localparam int FLG_TEMP_OK  = 6;
  localparam int FLG_TEMP_HOT = 7;
  localparam int FLG_PWR_GOOD = 8;
  localparam int FLG_REF_GOOD = 9;
  localparam int FLG_BIAS_OK  = 10;

  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [7:0]  CTRL_OFFSET   = 8'h00;
  localparam logic [7:0]  STATUS_OFFSET = 8'h04;
  localparam logic [7:0]  TIMER_OFFSET  = 8'h08;
  localparam int          CTRL_STOP_BIT = 0;
  localparam logic        CTRL_RESET    = 1'h0;
  localparam int          ST_STATE_LSB  = 0;
  localparam int          ST_FLAG_LSB   = 4;
  localparam int          ST_TEMP_BIT   = 16;

  ////////////////////////////////////////////////////////////////////////////
  // States and current commands
  typedef enum logic [2:0] {
    LBCS_RESET  = 3'h0,
    LBCS_PREQ   = 3'h1,
    LBCS_FAST   = 3'h3,
    LBCS_FULL   = 3'h2,
    LBCS_TOPOFF = 3'h6,
    LBCS_DONE   = 3'h7,
    LBCS_SUSP   = 3'h5,
    LBCS_FAULT  = 3'h4
  } lbcs_state_e;

  typedef enum logic [1:0] {
    LBCS_I_OFF   = 2'h0,
    LBCS_I_TENTH = 2'h1,
    LBCS_I_FULL  = 2'h2
  } lbcs_isel_e;

endpackage

`default_nettype wire

// >>> design/lbcs_sync.sv
// Purpose: Two-flop synchroniser, one per flag bit
// Assumes: Asynchronous active-low reset
// Notes:   First stage is read by the second stage only
`default_nettype none

module lbcs_sync #(
  parameter int W = 1
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  for (genvar i = 0; i < W; i++) begin : g_bit
    logic meta_q;
    logic sync_q;
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        meta_q <= 1'b0;
        sync_q <= 1'b0;
      end else begin
        meta_q <= async_in[i];
        sync_q <= meta_q;
      end
    end
    assign sync_out[i] = sync_q;
  end

endmodule

`default_nettype wire

// >>> design/lbcs_sequencer.sv
// Purpose: Li-ion charge sequencer with safety timers and AHB-Lite status
// Assumes: Flags from the analog front end are asynchronous levels
// Notes:   Indicators are open drain; oe high means pulling low
//
// Contract
// - Reset: timers cleared, zero current, indicators high
// - Reset on power-up, recharge, dropout, overvoltage
// - Shutdown release or power-up restarts with zeroed timers
// - Reset to prequal once supplies are good
// - Reset to fault when battery too hot
// - Prequal: tenth current, fast indicator low
// - Prequal timeout on short timer means fault
// - Prequal to fast above undervoltage, temperature good
// - Prequal suspends and resumes with temperature
// - Fast: full current, fast indicator, bulk timer
// - Fast to full on regulation voltage
// - Fast timeout before regulation means fault
// - Full: constant voltage, full indicator, 90-minute timer as long as fast
// - Full to top-off on taper or timeout
// - Top-off: constant voltage, indicators high, then done
// - Done: zero current until recharge, then reset
// - Bad temperature: zero current, frozen timer, resume
// - Fault: zero current, fault indicator low
// - Fault left only by power or shutdown; the code also leaves it when the CTRL stop bit is set
// - Shutdown: stop, switch off, indicators released
// - Temperature sampled at 1.12 Hz, charging halted
//
// Local design decisions: the register addresses and register access over AHB-Lite.
`default_nettype none

module lbcs_sequencer #(
  parameter int unsigned TICK_CYCLES  = lbcs_pkg::TICK_CYCLES,
  parameter int unsigned PREQ_TICKS   = lbcs_pkg::PREQ_TICKS,
  parameter int unsigned FAST_TICKS   = lbcs_pkg::FAST_TICKS,
  parameter int unsigned FULL_TICKS   = lbcs_pkg::FULL_TICKS,
  parameter int unsigned TOPOFF_TICKS = lbcs_pkg::TOPOFF_TICKS,
  parameter int unsigned TEMP_TICKS   = lbcs_pkg::TEMP_TICKS
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        shutdown_input_n,
  input  wire logic        batt_above_uv,
  input  wire logic        batt_at_regulation,
  input  wire logic        batt_below_recharge,
  input  wire logic        batt_overvoltage,
  input  wire logic        supply_dropout,
  input  wire logic        taper_current_low,
  input  wire logic        temp_in_window,
  input  wire logic        temp_at_max,
  input  wire logic        input_power_good,
  input  wire logic        reference_good,
  input  wire logic        bias_good,
  output logic      [1:0]  charge_current_sel,
  output logic             constant_voltage_sel,
  output logic             high_side_enable,
  output logic             fast_charge_indicator_n_out,
  output logic             fast_charge_indicator_n_oe,
  output logic             full_charge_indicator_n_out,
  output logic             full_charge_indicator_n_oe,
  output logic             fault_indicator_n_out,
  output logic             fault_indicator_n_oe
);

  localparam int TW = lbcs_pkg::TIMER_W;

  logic [lbcs_pkg::FLAG_W-1:0] flags_raw;
  logic [lbcs_pkg::FLAG_W-1:0] flags;
  lbcs_pkg::lbcs_state_e       state_q;
  lbcs_pkg::lbcs_state_e       state_d;
  lbcs_pkg::lbcs_state_e       resume_q;
  logic [15:0]                 tick_cnt_q;
  logic                        tick;
  logic [15:0]                 temp_cnt_q;
  logic                        measuring;
  logic                        temp_ok_q;
  logic                        temp_hot_q;
  logic [TW-1:0]               timer_q;
  logic [TW-1:0]               limit;
  logic                        expired;
  logic                        running;
  logic                        charger_on;
  logic                        leave_chg;
  logic                        ctrl_stop_q;
  logic                        ind_fast_q;
  logic                        ind_full_q;
  logic                        ind_fault_q;
  logic                        wr_pend_q;
  logic [7:0]                  addr_q;
  logic [31:0]                 rdata_q;
  logic                        addr_phase;
  logic [31:0]                 rd_mux;

  ////////////////////////////////////////////////////////////////////////////
  // Flag synchronisation
  assign flags_raw = {bias_good, reference_good, input_power_good,
                      temp_at_max, temp_in_window, taper_current_low,
                      supply_dropout, batt_overvoltage, batt_below_recharge,
                      batt_at_regulation, batt_above_uv};

  lbcs_sync #(.W(lbcs_pkg::FLAG_W)) u_sync (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .async_in (flags_raw),
    .sync_out (flags)
  );

  assign charger_on = shutdown_input_n && !ctrl_stop_q;
  assign leave_chg  = flags[lbcs_pkg::FLG_DROPOUT]
                   || flags[lbcs_pkg::FLG_OVERVOLT];

  ////////////////////////////////////////////////////////////////////////////
  // Timer tick prescaler and temperature sampling
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt_q <= 16'h0000;
    end else if (tick) begin
      tick_cnt_q <= 16'h0000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 16'h0001;
    end
  end
  assign tick = (tick_cnt_q == 16'(TICK_CYCLES - 1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      temp_cnt_q <= 16'h0000;
      temp_ok_q  <= 1'b0;
      temp_hot_q <= 1'b0;
    end else if (tick) begin
      if (measuring) begin
        temp_cnt_q <= 16'h0000;
        temp_ok_q  <= flags[lbcs_pkg::FLG_TEMP_OK];
        temp_hot_q <= flags[lbcs_pkg::FLG_TEMP_HOT];
      end else begin
        temp_cnt_q <= temp_cnt_q + 16'h0001;
      end
    end
  end
  assign measuring = (temp_cnt_q == 16'(TEMP_TICKS - 1));

  ////////////////////////////////////////////////////////////////////////////
  // Safety timer
  always_comb begin
    unique case (state_q)
      lbcs_pkg::LBCS_PREQ:   limit = TW'(PREQ_TICKS);
      lbcs_pkg::LBCS_FAST:   limit = TW'(FAST_TICKS);
      lbcs_pkg::LBCS_FULL:   limit = TW'(FULL_TICKS);
      lbcs_pkg::LBCS_TOPOFF: limit = TW'(TOPOFF_TICKS);
      default:               limit = {TW{1'b1}};
    endcase
  end
  assign running = (state_q == lbcs_pkg::LBCS_PREQ)
                || (state_q == lbcs_pkg::LBCS_FAST)
                || (state_q == lbcs_pkg::LBCS_FULL)
                || (state_q == lbcs_pkg::LBCS_TOPOFF);
  assign expired = running && (timer_q >= limit);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_q <= '0;
    end else if (!charger_on || state_q == lbcs_pkg::LBCS_RESET) begin
      timer_q <= '0;
    end else if (state_d != state_q && state_d != lbcs_pkg::LBCS_SUSP
                 && state_q != lbcs_pkg::LBCS_SUSP) begin
      timer_q <= '0;
    end else if (running && tick && !expired) begin
      timer_q <= timer_q + TW'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Charge state machine
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      lbcs_pkg::LBCS_RESET: begin
        if (temp_hot_q) begin
          state_d = lbcs_pkg::LBCS_FAULT;
        end else if (flags[lbcs_pkg::FLG_PWR_GOOD]
                     && flags[lbcs_pkg::FLG_REF_GOOD]
                     && flags[lbcs_pkg::FLG_BIAS_OK]) begin
          state_d = lbcs_pkg::LBCS_PREQ;
        end
      end
      lbcs_pkg::LBCS_PREQ: begin
        if (expired) begin
          state_d = lbcs_pkg::LBCS_FAULT;
        end else if (!temp_ok_q) begin
          state_d = lbcs_pkg::LBCS_SUSP;
        end else if (flags[lbcs_pkg::FLG_ABOVE_UV]) begin
          state_d = lbcs_pkg::LBCS_FAST;
        end
      end
      lbcs_pkg::LBCS_FAST: begin
        if (flags[lbcs_pkg::FLG_AT_REG]) begin
          state_d = lbcs_pkg::LBCS_FULL;
        end else if (expired) begin
          state_d = lbcs_pkg::LBCS_FAULT;
        end else if (!temp_ok_q) begin
          state_d = lbcs_pkg::LBCS_SUSP;
        end
      end
      lbcs_pkg::LBCS_FULL: begin
        if (flags[lbcs_pkg::FLG_TAPER] || expired) begin
          state_d = lbcs_pkg::LBCS_TOPOFF;
        end else if (!temp_ok_q) begin
          state_d = lbcs_pkg::LBCS_SUSP;
        end
      end
      lbcs_pkg::LBCS_TOPOFF: begin
        if (expired) begin
          state_d = lbcs_pkg::LBCS_DONE;
        end else if (!temp_ok_q) begin
          state_d = lbcs_pkg::LBCS_SUSP;
        end
      end
      lbcs_pkg::LBCS_DONE: begin
        if (flags[lbcs_pkg::FLG_RECHARGE]) begin
          state_d = lbcs_pkg::LBCS_RESET;
        end
      end
      lbcs_pkg::LBCS_SUSP: begin
        if (temp_ok_q) begin
          state_d = resume_q;
        end
      end
      lbcs_pkg::LBCS_FAULT: begin
        state_d = lbcs_pkg::LBCS_FAULT;
      end
    endcase
    if (leave_chg && state_q != lbcs_pkg::LBCS_FAULT) begin
      state_d = lbcs_pkg::LBCS_RESET;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= lbcs_pkg::LBCS_RESET;
    end else if (!charger_on) begin
      state_q <= lbcs_pkg::LBCS_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      resume_q <= lbcs_pkg::LBCS_PREQ;
    end else if (state_d == lbcs_pkg::LBCS_SUSP
                 && state_q != lbcs_pkg::LBCS_SUSP) begin
      resume_q <= state_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Indicators, held through temperature suspension
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ind_fast_q  <= 1'b0;
      ind_full_q  <= 1'b0;
      ind_fault_q <= 1'b0;
    end else if (state_q != lbcs_pkg::LBCS_SUSP) begin
      ind_fast_q  <= (state_q == lbcs_pkg::LBCS_PREQ)
                  || (state_q == lbcs_pkg::LBCS_FAST);
      ind_full_q  <= (state_q == lbcs_pkg::LBCS_FULL);
      ind_fault_q <= (state_q == lbcs_pkg::LBCS_FAULT);
    end
  end

  assign fast_charge_indicator_n_out = 1'b0;
  assign full_charge_indicator_n_out = 1'b0;
  assign fault_indicator_n_out       = 1'b0;
  assign fast_charge_indicator_n_oe  = ind_fast_q && shutdown_input_n;
  assign full_charge_indicator_n_oe  = ind_full_q && shutdown_input_n;
  assign fault_indicator_n_oe        = ind_fault_q && shutdown_input_n;
  // Released in shutdown; all released in reset

  ////////////////////////////////////////////////////////////////////////////
  // Power stage commands
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      charge_current_sel   <= lbcs_pkg::LBCS_I_OFF;
      constant_voltage_sel <= 1'b0;
    end else if (!charger_on || measuring) begin
      charge_current_sel   <= lbcs_pkg::LBCS_I_OFF;
      constant_voltage_sel <= 1'b0;
    end else begin
      unique case (state_d)
        lbcs_pkg::LBCS_PREQ: begin
          charge_current_sel   <= lbcs_pkg::LBCS_I_TENTH;
          constant_voltage_sel <= 1'b0;
        end
        lbcs_pkg::LBCS_FAST: begin
          charge_current_sel   <= lbcs_pkg::LBCS_I_FULL;
          constant_voltage_sel <= 1'b0;
        end
        lbcs_pkg::LBCS_FULL, lbcs_pkg::LBCS_TOPOFF: begin
          charge_current_sel   <= lbcs_pkg::LBCS_I_FULL;
          constant_voltage_sel <= 1'b1;
        end
        default: begin
          charge_current_sel   <= lbcs_pkg::LBCS_I_OFF;
          constant_voltage_sel <= 1'b0;
        end
      endcase
    end
  end
  assign high_side_enable = (charge_current_sel != lbcs_pkg::LBCS_I_OFF)
                         && shutdown_input_n;

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave, zero wait states
  assign addr_phase = hsel && hready && htrans[1];
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign hrdata     = rdata_q;

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (haddr[7:0])
      lbcs_pkg::CTRL_OFFSET:
        rd_mux[lbcs_pkg::CTRL_STOP_BIT] = ctrl_stop_q;
      lbcs_pkg::STATUS_OFFSET: begin
        rd_mux[lbcs_pkg::ST_STATE_LSB +: 3] = state_q;
        rd_mux[lbcs_pkg::ST_FLAG_LSB +: lbcs_pkg::FLAG_W] = flags;
        rd_mux[lbcs_pkg::ST_TEMP_BIT] = temp_ok_q;
      end
      lbcs_pkg::TIMER_OFFSET:
        rd_mux[TW-1:0] = timer_q;
      default: rd_mux = 32'h0000_0000;
    endcase
    if (haddr[31:8] != 24'h00_0000) begin
      rd_mux = 32'h0000_0000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      addr_q    <= 8'h00;
      rdata_q   <= 32'h0000_0000;
    end else begin
      wr_pend_q <= addr_phase && hwrite && (haddr[31:8] == 24'h00_0000);
      if (addr_phase) begin
        addr_q <= haddr[7:0];
      end
      if (addr_phase && !hwrite) begin
        rdata_q <= rd_mux;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_stop_q <= lbcs_pkg::CTRL_RESET;
    end else if (wr_pend_q && addr_q == lbcs_pkg::CTRL_OFFSET) begin
      ctrl_stop_q <= hwdata[lbcs_pkg::CTRL_STOP_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_reset_idle: assert property (
    @(posedge hclk) disable iff (!hresetn)
    state_q == lbcs_pkg::LBCS_RESET |=> charge_current_sel
      == lbcs_pkg::LBCS_I_OFF || state_q != lbcs_pkg::LBCS_RESET)
    else $error("current commanded out of reset");

  chk_preq_tenth: assert property (
    @(posedge hclk) disable iff (!hresetn)
    state_q == lbcs_pkg::LBCS_PREQ && $past(state_q) == lbcs_pkg::LBCS_PREQ
      && charger_on && !$past(measuring) |-> charge_current_sel
      == lbcs_pkg::LBCS_I_TENTH)
    else $error("prequal current not one tenth");

  chk_preq_timeout: assert property (
    @(posedge hclk) disable iff (!hresetn)
    state_q == lbcs_pkg::LBCS_PREQ && expired && charger_on && !leave_chg
      |=> state_q == lbcs_pkg::LBCS_FAULT)
    else $error("prequal timeout did not fault");

  chk_fast_full: assert property (
    @(posedge hclk) disable iff (!hresetn)
    state_q == lbcs_pkg::LBCS_FAST && flags[lbcs_pkg::FLG_AT_REG]
      && charger_on && !leave_chg |=> state_q == lbcs_pkg::LBCS_FULL)
    else $error("regulation did not enter full charge");

  chk_fault_held: assert property (
    @(posedge hclk) disable iff (!hresetn)
    state_q == lbcs_pkg::LBCS_FAULT && charger_on
      |=> state_q == lbcs_pkg::LBCS_FAULT ##1 fault_indicator_n_oe
      || !shutdown_input_n)
    else $error("fault left without shutdown");

  chk_susp_freeze: assert property (
    @(posedge hclk) disable iff (!hresetn)
    state_q == lbcs_pkg::LBCS_SUSP && charger_on
      |=> $stable(timer_q) || !charger_on || $past(leave_chg))
    else $error("timer moved while suspended");

  chk_shutdown_input_n_release: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !shutdown_input_n |-> !high_side_enable && !fast_charge_indicator_n_oe
      && !full_charge_indicator_n_oe && !fault_indicator_n_oe)
    else $error("pins driven during shutdown");

  chk_done_recharge: assert property (
    @(posedge hclk) disable iff (!hresetn)
    state_q == lbcs_pkg::LBCS_DONE && flags[lbcs_pkg::FLG_RECHARGE]
      && charger_on |=> state_q == lbcs_pkg::LBCS_RESET
      && charge_current_sel == lbcs_pkg::LBCS_I_OFF)
    else $error("recharge did not restart");

  chk_meas_halt: assert property (
    @(posedge hclk) disable iff (!hresetn)
    measuring && tick |=> charge_current_sel == lbcs_pkg::LBCS_I_OFF)
    else $error("charging during temperature sample");

  cov_fast_charge: cover property (
    @(posedge hclk) disable iff (!hresetn)
    state_q == lbcs_pkg::LBCS_FAST);
  cov_topoff_done: cover property (
    @(posedge hclk) disable iff (!hresetn)
    state_q == lbcs_pkg::LBCS_TOPOFF ##1 state_q == lbcs_pkg::LBCS_DONE);
  cov_suspend: cover property (
    @(posedge hclk) disable iff (!hresetn)
    state_q == lbcs_pkg::LBCS_SUSP ##1 state_q != lbcs_pkg::LBCS_SUSP);
  cov_fault: cover property (
    @(posedge hclk) disable iff (!hresetn)
    state_q == lbcs_pkg::LBCS_FAULT);

endmodule

`default_nettype wire

// >>> verif/lbcs_led_model.sv
// Purpose: Indicator LEDs on pull-ups at the far side of the open drains
// Assumes: oe high pulls the line low
// Notes:   A released line reads high through its pull-up
`default_nettype none

module lbcs_led_model (
  input  wire logic       fast_oe,
  input  wire logic       full_oe,
  input  wire logic       fault_oe,
  output logic      [2:0] led
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pull-up level whenever released
  assign led = ~{fast_oe, full_oe, fault_oe};
endmodule

`default_nettype wire

// >>> verif/test_li_battery_charge_sequencer.sv
// Purpose: Self-checking bench of the charge sequencer
// Assumes: Short timer parameters, zero-wait bus
// Notes:   Polls STATUS; a table gives the outputs of each state
`default_nettype none

module test_li_battery_charge_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk = 1'h0;
  logic        hresetn = 1'h0;
  logic        hsel = 1'h0;
  logic        hwrite = 1'h0;
  logic        sn = 1'h1;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] d;
  logic [10:0] f = 11'h000;
  logic        hreadyout;
  logic        hse;
  logic        cv;
  logic [1:0]  isel;
  logic [5:0]  io;
  logic [2:0]  led;
  logic [15:0] lf = 16'h2531;
  int          num_errors = 0;
  int          n_tests = 0;
  int          cyc = 0;
  logic        hresp;
  logic [2:0]  hsize = 3'h0;
  // Shortened timer base so every phase fits the run
  localparam int TICK   = 4;
  localparam int PREQ_T = 20;
  localparam int LONG_T = 30;
  localparam int TOP_T  = 20;
  localparam int TEMP_T = 5;

  always #10 hclk = ~hclk;

  lbcs_sequencer #(.TICK_CYCLES(TICK), .PREQ_TICKS(PREQ_T),
    .FAST_TICKS(LONG_T), .FULL_TICKS(LONG_T), .TOPOFF_TICKS(TOP_T),
    .TEMP_TICKS(TEMP_T)) u_lbcs_sequencer (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .shutdown_input_n(sn), .batt_above_uv(f[0]),
    .batt_at_regulation(f[1]), .batt_below_recharge(f[2]),
    .batt_overvoltage(f[3]), .supply_dropout(f[4]),
    .taper_current_low(f[5]), .temp_in_window(f[6]), .temp_at_max(f[7]),
    .input_power_good(f[8]), .reference_good(f[9]), .bias_good(f[10]),
    .charge_current_sel(isel), .constant_voltage_sel(cv),
    .high_side_enable(hse), .fast_charge_indicator_n_out(io[5]),
    .fast_charge_indicator_n_oe(io[4]), .full_charge_indicator_n_out(io[3]),
    .full_charge_indicator_n_oe(io[2]), .fault_indicator_n_out(io[1]),
    .fault_indicator_n_oe(io[0]));

  lbcs_led_model u_lbcs_led_model (.fast_oe(io[4]), .full_oe(io[2]),
    .fault_oe(io[0]), .led(led));

  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task conclude;
    $display("mismatches=%0d checks=%0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  function automatic logic [15:0] nx(input logic [15:0] v);
    nx = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  // Model: check-current flag, current, cv, LED levels fast/full/fault
  function automatic logic [6:0] mdl(input logic [2:0] s);
    case (s)
      3'h1: mdl = 7'h53;
      3'h3: mdl = 7'h63;
      3'h2: mdl = 7'h0D;
      3'h6: mdl = 7'h0F;
      3'h4: mdl = 7'h46;
      3'h5: mdl = 7'h40;
      default: mdl = 7'h47;
    endcase
  endfunction

  task xf(input logic w, input logic [31:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'h1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask

  task st(input logic [2:0] s);
    logic [6:0] m;
    m = mdl(s);
    for (int i = 0; i < 300; i++) begin
      xf(1'h0, 32'h4, 32'h0);
      if (d[2:0] === s) break;
    end
    chk(d[2:0], s);
    repeat (3) @(posedge hclk);
    for (int i = 0; i < 8 && m[5:4] != 0 && isel === 2'h0; i++)
      @(posedge hclk);
    if (m[6]) chk(isel, m[5:4]);
    if (s != 3'h5) chk({cv, led}, m[3:0]);
  endtask

  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      num_errors++;
      conclude;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'h1;
    st(3'h0);
    xf(1'h0, 32'h8, 32'h0);
    chk(d, 32'h0);
    for (int i = 0; i < 4; i++) begin
      lf = nx(lf);
      xf(1'h0, {lf, 16'h0000}, 32'h0);
      chk(d, 32'h0);
      xf(1'h1, 32'h0, {lf, 16'h0000});
    end
    f <= 11'h740;
    st(3'h1);
    f[6] <= 1'h0;
    st(3'h5);
    f[6] <= 1'h1;
    st(3'h1);
    f[0] <= 1'h1;
    st(3'h3);
    f[6] <= 1'h0;
    st(3'h5);
    f[6] <= 1'h1;
    st(3'h3);
    f[1] <= 1'h1;
    st(3'h2);
    f[5] <= 1'h1;
    st(3'h6);
    st(3'h7);
    f <= 11'h745;
    st(3'h3);
    xf(1'h1, 32'h0, 32'h1);
    st(3'h0);
    xf(1'h0, 32'h8, 32'h0);
    chk(d, 32'h0);
    xf(1'h1, 32'h0, 32'h0);
    st(3'h3);
    f[8] <= 1'h0;
    f[4] <= 1'h1;
    st(3'h0);
    f <= 11'h740;
    st(3'h4);
    f[3] <= 1'h1;
    repeat (20) @(posedge hclk);
    st(3'h4);
    sn <= 1'h0;
    repeat (3) @(posedge hclk);
    chk({hse, led, io[4], io[2], io[0]}, 7'h38);
    chk({hresp, io[5], io[3], io[1]}, 32'h0);
    f <= 11'h680;
    sn <= 1'h1;
    st(3'h4);
    sn <= 1'h0;
    f <= 11'h741;
    // Let a fresh temperature sample clear the hot reading
    repeat (30) @(posedge hclk);
    sn <= 1'h1;
    st(3'h3);
    st(3'h4);
    conclude;
  end
endmodule

`default_nettype wire
